//--- rtl/spm_pkg.sv
// constants and types for the scratch-pad and sram page address mapper
// Function
// - scratch-pad holds 256 bytes, byte-wide address
// - upper half: direct to peripherals, indirect to ram
// - lower half same ram in both modes
// - lowest 32 bytes are four register banks
// - 128 KB sram, paging mode from pin
// - pin low: two pages of 64 KB
// - pin high: eight pages of 16 KB
// - location named by page and 16-bit address
// - physical address is block over address bits 13:0
// - mode 0: page lsb over address 15:0
// - mode 1: page is block, address 13:0 offset
// - program page register resets to 0
// - data read and write pages reset to 1
// - fetch and code-table read use program page
// - external data writes use data write page
// - external data reads use data read page
// - logical range spans 00000 to 7FFFF
// - any sram location serves code and data
package spm_pkg;
    // =====================================================================
    // sizes
    localparam int SPM_SP_BYTES = 256;
    localparam int SPM_SRAM_BYTES = 131072;
    localparam int SPM_PHYS_W = 17;
    localparam int SPM_BLOCK_W = 5;
    localparam int SPM_OFFS_W = 14;
    localparam logic [2:0] SPM_SP_HALF_BIT = 3'h7;
    // =====================================================================
    // register map, byte addresses on the register bus
    localparam logic [7:0] SPM_REG_PROG_PAGE = 8'h00;
    localparam logic [7:0] SPM_REG_DRD_PAGE = 8'h04;
    localparam logic [7:0] SPM_REG_DWR_PAGE = 8'h08;
    localparam logic [7:0] SPM_REG_STATUS = 8'h0C;
    localparam int SPM_STAT_MODE_BIT = 0;
    localparam int SPM_STAT_PHYS_LSB = 8;
    // =====================================================================
    // reset values
    localparam logic [2:0] SPM_PROG_PAGE_RST = 3'h0;
    localparam logic [2:0] SPM_DATA_PAGE_RST = 3'h1;
    localparam logic [1:0] SPM_RESP_OKAY = 2'h0;
    localparam logic [1:0] SPM_RESP_SLVERR = 2'h2;
    // =====================================================================
    // types
    typedef enum logic [1:0] {
        SPM_FETCH = 2'b00,
        SPM_CODE_READ = 2'b01,
        SPM_DATA_READ = 2'b10,
        SPM_DATA_WRITE = 2'b11
    } spm_kind_t;
    typedef struct packed {
        logic we;
        logic indirect;
        logic is_reg;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spm_sp_req_t;
    typedef struct packed {
        spm_kind_t kind;
        logic [15:0] ptr;
        logic [7:0] wdata;
    } spm_mem_req_t;
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spm_periph_t;
endpackage : spm_pkg

//--- rtl/spm_mapper.sv
// scratch-pad decoder, working-register banks and paged sram mapper
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module spm_mapper import spm_pkg::*; #(
    parameter int SP_BYTES = SPM_SP_BYTES,
    parameter int SRAM_BYTES = SPM_SRAM_BYTES
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    // paging mode pin
    input wire logic paging_mode_select,
    // scratch-pad request from the core
    input wire logic sp_req,
    input wire spm_sp_req_t sp_req_i,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    output logic [7:0] sp_rdata_ff,
    output logic sp_rvalid_ff,
    // peripheral control space access
    output logic periph_req_ff,
    output spm_periph_t periph_ff,
    // sram request from fetch and data-move units
    input wire logic mem_req,
    input wire spm_mem_req_t mem_req_i,
    output logic [7:0] mem_rdata_ff,
    output logic mem_rvalid_ff,
    output logic [SPM_PHYS_W-1:0] mem_phys_ff,
    // axi4-lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready_ff,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready_ff,
    output logic [1:0] s_bresp_ff,
    output logic s_bvalid_ff,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready_ff,
    output logic [31:0] s_rdata_ff,
    output logic [1:0] s_rresp_ff,
    output logic s_rvalid_ff,
    input wire logic s_rready
);
    // =====================================================================
    // storage
    logic [7:0] sp_ram [SP_BYTES];  // byte-wide index only
    logic [7:0] sram [SRAM_BYTES];
    logic [2:0] program_page_ff;
    logic [2:0] data_read_page_ff;
    logic [2:0] data_write_page_ff;
    logic mode_meta_ff;
    logic mode_sync_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic [7:0] sp_index;
    logic sp_to_periph;
    logic [2:0] mem_page;
    logic [SPM_PHYS_W-1:0] nxt_phys;
    logic [SPM_BLOCK_W-1:0] phys_block;
    logic wr_fire;
    logic [31:0] nxt_rdata;
    logic nxt_rd_ok;

    // =====================================================================
    // paging pin synchroniser
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode_meta_ff <= 1'b0;
            mode_sync_ff <= 1'b0;
        end else if (clk_en) begin
            mode_meta_ff <= paging_mode_select;
            mode_sync_ff <= mode_meta_ff;
        end
    end

    // =====================================================================
    // scratch-pad decode
    always_comb begin
        sp_index = sp_req_i.addr;
        if (sp_req_i.is_reg) begin
            // bank times eight plus register number
            sp_index = {3'h0, bank_select_high, bank_select_low,
                        sp_req_i.addr[2:0]};
        end
        // upper half direct goes out, indirect stays in ram
        sp_to_periph = !sp_req_i.is_reg && !sp_req_i.indirect
                       && sp_req_i.addr[SPM_SP_HALF_BIT];
    end

    // scratch-pad ram, lower half identical for both modes
    always_ff @(posedge mclk) begin
        if (clk_en && sp_req && !sp_to_periph && sp_req_i.we) begin
            sp_ram[sp_index] <= sp_req_i.wdata;
        end
    end

    // scratch-pad read answer and peripheral forward
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sp_rdata_ff <= 8'h00;
            sp_rvalid_ff <= 1'b0;
            periph_req_ff <= 1'b0;
            periph_ff <= '0;
        end else if (clk_en) begin
            sp_rvalid_ff <= sp_req && !sp_to_periph && !sp_req_i.we;
            if (sp_req && !sp_to_periph && !sp_req_i.we) begin
                sp_rdata_ff <= sp_ram[sp_index];
            end
            periph_req_ff <= sp_req && sp_to_periph;
            if (sp_req && sp_to_periph) begin
                periph_ff <= '{we: sp_req_i.we, addr: sp_req_i.addr,
                               wdata: sp_req_i.wdata};
            end
        end
    end

    // =====================================================================
    // page choice and physical address
    always_comb begin
        case (mem_req_i.kind)
            SPM_FETCH, SPM_CODE_READ: mem_page = program_page_ff;
            SPM_DATA_WRITE: mem_page = data_write_page_ff;
            SPM_DATA_READ: mem_page = data_read_page_ff;
            default: mem_page = program_page_ff;
        endcase
        // 3-bit page plus 16-bit pointer, page bits 2:1 (mode 0) or pointer bits 15:14 (mode 1) dropped
        if (!mode_sync_ff) begin
            nxt_phys = {mem_page[0], mem_req_i.ptr};
        end else begin
            nxt_phys = {mem_page, mem_req_i.ptr[13:0]};
        end
        // block number always keeps its top two bits clear
        phys_block = {2'b00, nxt_phys[SPM_PHYS_W-1:SPM_OFFS_W]};
    end

    // one shared array for code and data, one port, read data held during a write
    always_ff @(posedge mclk) begin
        if (clk_en && mem_req && mem_req_i.kind == SPM_DATA_WRITE) begin
            sram[nxt_phys] <= mem_req_i.wdata;
        end
    end

    // sram read answer and address trace
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mem_rdata_ff <= 8'h00;
            mem_rvalid_ff <= 1'b0;
            mem_phys_ff <= '0;
        end else if (clk_en) begin
            mem_rvalid_ff <= mem_req && mem_req_i.kind != SPM_DATA_WRITE;
            if (mem_req) begin
                mem_phys_ff <= {phys_block[2:0],
                                nxt_phys[SPM_OFFS_W-1:0]};
                if (mem_req_i.kind != SPM_DATA_WRITE) begin
                    mem_rdata_ff <= sram[nxt_phys];
                end
            end
        end
    end

    // =====================================================================
    // axi4-lite write address and data capture
    assign wr_fire = !s_awready_ff && !s_wready_ff && !s_bvalid_ff;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_awready_ff <= 1'b1;
            aw_addr_ff <= 8'h00;
        end else if (clk_en) begin
            if (s_awvalid && s_awready_ff) begin
                s_awready_ff <= 1'b0;
                aw_addr_ff <= s_awaddr;
            end else if (s_bvalid_ff && s_bready) begin
                s_awready_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_wready_ff <= 1'b1;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end else if (clk_en) begin
            if (s_wvalid && s_wready_ff) begin
                s_wready_ff <= 1'b0;
                w_data_ff <= s_wdata;
                w_strb_ff <= s_wstrb;
            end else if (s_bvalid_ff && s_bready) begin
                s_wready_ff <= 1'b1;
            end
        end
    end

    // write response once both halves are held
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_bvalid_ff <= 1'b0;
            s_bresp_ff <= SPM_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_bvalid_ff <= 1'b1;
                s_bresp_ff <= (aw_addr_ff == SPM_REG_PROG_PAGE
                               || aw_addr_ff == SPM_REG_DRD_PAGE
                               || aw_addr_ff == SPM_REG_DWR_PAGE
                               || aw_addr_ff == SPM_REG_STATUS)
                              ? SPM_RESP_OKAY : SPM_RESP_SLVERR;
            end else if (s_bready) begin
                s_bvalid_ff <= 1'b0;
            end
        end
    end

    // page registers, byte lane 0 only
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            program_page_ff <= SPM_PROG_PAGE_RST;
            data_read_page_ff <= SPM_DATA_PAGE_RST;
            data_write_page_ff <= SPM_DATA_PAGE_RST;
        end else if (clk_en && wr_fire && w_strb_ff[0]) begin
            case (aw_addr_ff)
                SPM_REG_PROG_PAGE: program_page_ff <= w_data_ff[2:0];
                SPM_REG_DRD_PAGE: data_read_page_ff <= w_data_ff[2:0];
                SPM_REG_DWR_PAGE: data_write_page_ff <= w_data_ff[2:0];
                default: ;
            endcase
        end
    end

    // =====================================================================
    // axi4-lite read
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_rd_ok = 1'b1;
        case (s_araddr)
            SPM_REG_PROG_PAGE: nxt_rdata[2:0] = program_page_ff;
            SPM_REG_DRD_PAGE: nxt_rdata[2:0] = data_read_page_ff;
            SPM_REG_DWR_PAGE: nxt_rdata[2:0] = data_write_page_ff;
            SPM_REG_STATUS: begin
                nxt_rdata[SPM_STAT_MODE_BIT] = mode_sync_ff;
                nxt_rdata[SPM_STAT_PHYS_LSB +: SPM_PHYS_W] = mem_phys_ff;
            end
            default: nxt_rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_arready_ff <= 1'b1;
            s_rvalid_ff <= 1'b0;
            s_rdata_ff <= 32'h0000_0000;
            s_rresp_ff <= SPM_RESP_OKAY;
        end else if (clk_en) begin
            if (s_arvalid && s_arready_ff) begin
                s_arready_ff <= 1'b0;
                s_rvalid_ff <= 1'b1;
                s_rdata_ff <= nxt_rdata;
                s_rresp_ff <= nxt_rd_ok ? SPM_RESP_OKAY : SPM_RESP_SLVERR;
            end else if (s_rvalid_ff && s_rready) begin
                s_rvalid_ff <= 1'b0;
                s_arready_ff <= 1'b1;
            end
        end
    end

    // =====================================================================
    // checks
    periph_route_a: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && sp_req && !sp_req_i.is_reg && !sp_req_i.indirect
        && sp_req_i.addr[7] |=> periph_req_ff && !sp_rvalid_ff
        && periph_ff.addr == $past(sp_req_i.addr))
        else $error("direct upper access not sent to peripherals");

    upper_indirect_a: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && sp_req && sp_req_i.indirect && !sp_req_i.we
        |=> !periph_req_ff && sp_rvalid_ff)
        else $error("indirect access left the scratch-pad ram");

    low_same_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (clk_en && sp_req && sp_req_i.we && !sp_req_i.is_reg
         && !sp_req_i.addr[7]) ##1 (clk_en && sp_req && !sp_req_i.we
         && !sp_req_i.is_reg && sp_req_i.addr == $past(sp_req_i.addr))
        |=> sp_rdata_ff == $past(sp_req_i.wdata, 2))
        else $error("lower scratch-pad differs between modes");

    bank_map_a: assert property (@(posedge mclk) disable iff (!reset_n)
        sp_req_i.is_reg |-> sp_index == {3'h0, bank_select_high,
        bank_select_low, sp_req_i.addr[2:0]} && !sp_to_periph)
        else $error("working register bank index wrong");

    mode0_map_a: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && mem_req && !mode_sync_ff |=> mem_phys_ff ==
        {$past(mem_page[0]), $past(mem_req_i.ptr)})
        else $error("mode 0 physical address wrong");

    mode1_map_a: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && mem_req && mode_sync_ff |=> mem_phys_ff ==
        {$past(mem_page), $past(mem_req_i.ptr[13:0])})
        else $error("mode 1 physical address wrong");

    page_source_a: assert property (@(posedge mclk) disable iff (!reset_n)
        mem_req_i.kind == SPM_DATA_WRITE |-> mem_page == data_write_page_ff)
        else $error("data write used the wrong page");

    read_page_a: assert property (@(posedge mclk) disable iff (!reset_n)
        mem_req_i.kind == SPM_DATA_READ |-> mem_page == data_read_page_ff)
        else $error("data read used the wrong page");

    page_reset_a: assert property (@(posedge mclk)
        $rose(reset_n) |-> program_page_ff == 3'h0
        && data_read_page_ff == 3'h1 && data_write_page_ff == 3'h1)
        else $error("page registers not at reset values");

    code_data_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (clk_en && mem_req && mem_req_i.kind == SPM_DATA_WRITE)
        ##1 (clk_en && mem_req && mem_req_i.kind == SPM_FETCH
             && nxt_phys == $past(nxt_phys))
        |=> mem_rdata_ff == $past(mem_req_i.wdata, 2))
        else $error("fetch missed the latest data write");

    // fetch and code-table reads take the program page
    fetch_page_a: assert property (@(posedge mclk) disable iff (!reset_n)
        mem_req_i.kind == SPM_FETCH || mem_req_i.kind == SPM_CODE_READ
        |-> mem_page == program_page_ff)
        else $error("fetch used the wrong page");

    // writes to the sram never raise a read answer
    write_quiet_a: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && mem_req && mem_req_i.kind == SPM_DATA_WRITE
        |=> !mem_rvalid_ff)
        else $error("sram write raised a read answer");

    // clock enable low freezes every answer
    freeze_outs_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !clk_en |=> $stable(sp_rdata_ff) && $stable(mem_rdata_ff)
        && $stable(mem_phys_ff) && $stable(s_bvalid_ff)
        && $stable(s_rvalid_ff))
        else $error("outputs moved while clock enable was low");

    // write response stands until the master takes it
    bvalid_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
        s_bvalid_ff && !s_bready |=> s_bvalid_ff)
        else $error("write response dropped before bready");

    // read answer and its data stand until the master takes them
    rvalid_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
        s_rvalid_ff && !s_rready |=> s_rvalid_ff && $stable(s_rdata_ff))
        else $error("read answer dropped before rready");

    // main scenarios reached
    cover_periph_c: cover property (@(posedge mclk) periph_req_ff);
    cover_mode1_c: cover property (@(posedge mclk)
        mem_rvalid_ff && mode_sync_ff);
    cover_axi_wr_c: cover property (@(posedge mclk)
        s_bvalid_ff && s_bready && s_bresp_ff == SPM_RESP_OKAY);
    cover_bank_c: cover property (@(posedge mclk)
        clk_en && sp_req && sp_req_i.is_reg);
    cover_code_c: cover property (@(posedge mclk)
        clk_en && mem_req && mem_req_i.kind == SPM_CODE_READ);
endmodule : spm_mapper

//--- tb/spm_core_model.sv
// core model issuing scratch-pad and sram requests to the mapper
`timescale 1ns/1ps
module spm_core_model import spm_pkg::*; (
    // clock
    input wire logic mclk,
    // scratch-pad side
    output logic sp_req,
    output spm_sp_req_t sp_req_i,
    output logic bank_select_low,
    output logic bank_select_high,
    input wire logic [7:0] sp_rdata_ff,
    input wire logic sp_rvalid_ff,
    input wire logic periph_req_ff,
    input wire spm_periph_t periph_ff,
    // sram side
    output logic mem_req,
    output spm_mem_req_t mem_req_i,
    input wire logic [7:0] mem_rdata_ff,
    input wire logic mem_rvalid_ff,
    input wire logic [SPM_PHYS_W-1:0] mem_phys_ff
);
    // =====================================================================
    // idle requests from time zero
    initial begin
        sp_req = 1'b0;
        sp_req_i = '0;
        bank_select_low = 1'b0;
        bank_select_high = 1'b0;
        mem_req = 1'b0;
        mem_req_i = '0;
    end
    // =====================================================================
    // one scratch-pad access, answer sampled the cycle after the take
    task automatic sp_access(input logic we, ind, isr, input logic [1:0] bk,
        input logic [7:0] a, d, output logic rv, pv, output logic [7:0] rd,
        output spm_periph_t pf);
        @(posedge mclk);
        sp_req <= 1'b1;
        sp_req_i <= '{we, ind, isr, a, d};
        {bank_select_high, bank_select_low} <= bk;
        @(posedge mclk);
        sp_req <= 1'b0;
        sp_req_i <= ~sp_req_i; // released payload does not keep its value
        #1;
        rv = sp_rvalid_ff;
        pv = periph_req_ff;
        rd = sp_rdata_ff;
        pf = periph_ff;
    endtask : sp_access
    // =====================================================================
    // one sram access of the given kind
    task automatic mem_access(input spm_kind_t k, input logic [15:0] p,
        input logic [7:0] d, output logic rv, output logic [7:0] rd,
        output logic [SPM_PHYS_W-1:0] ph);
        @(posedge mclk);
        mem_req <= 1'b1;
        mem_req_i <= '{k, p, d};
        @(posedge mclk);
        mem_req <= 1'b0;
        mem_req_i <= ~mem_req_i; // released payload does not keep its value
        #1;
        rv = mem_rvalid_ff;
        rd = mem_rdata_ff;
        ph = mem_phys_ff;
    endtask : mem_access
endmodule : spm_core_model

//--- tb/spm_mapper_test.sv
// self-checking bench for the scratch-pad and sram page mapper
`timescale 1ns/1ps
module spm_mapper_test import spm_pkg::*;;
    logic mclk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, paging_mode_select = 1'b0;
    logic sp_req, mem_req, bank_select_low, bank_select_high;
    spm_sp_req_t sp_req_i;
    spm_mem_req_t mem_req_i;
    spm_periph_t periph_ff;
    logic [7:0] sp_rdata_ff, mem_rdata_ff;
    logic sp_rvalid_ff, periph_req_ff, mem_rvalid_ff;
    logic [SPM_PHYS_W-1:0] mem_phys_ff;
    logic [7:0] s_awaddr = '0, s_araddr = '0;
    logic [31:0] s_wdata = '0, s_rdata_ff;
    logic [3:0] s_wstrb = '0;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
    logic s_awready_ff, s_wready_ff, s_bvalid_ff, s_arready_ff, s_rvalid_ff;
    logic [1:0] s_bresp_ff, s_rresp_ff;
    int num_errors = 0, n_checks = 0;
    logic rv, pv;
    logic [7:0] rd;
    logic [31:0] rw;
    logic [1:0] rs;
    spm_periph_t pf;
    logic [SPM_PHYS_W-1:0] ph;
    // =====================================================================
    // design and core model
    spm_mapper DUT (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
        .paging_mode_select(paging_mode_select), .sp_req(sp_req),
        .sp_req_i(sp_req_i), .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high), .sp_rdata_ff(sp_rdata_ff),
        .sp_rvalid_ff(sp_rvalid_ff), .periph_req_ff(periph_req_ff),
        .periph_ff(periph_ff), .mem_req(mem_req), .mem_req_i(mem_req_i),
        .mem_rdata_ff(mem_rdata_ff), .mem_rvalid_ff(mem_rvalid_ff),
        .mem_phys_ff(mem_phys_ff), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready_ff(s_awready_ff), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid), .s_wready_ff(s_wready_ff),
        .s_bresp_ff(s_bresp_ff), .s_bvalid_ff(s_bvalid_ff),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready_ff(s_arready_ff), .s_rdata_ff(s_rdata_ff),
        .s_rresp_ff(s_rresp_ff), .s_rvalid_ff(s_rvalid_ff),
        .s_rready(s_rready));
    spm_core_model core (.mclk(mclk), .sp_req(sp_req), .sp_req_i(sp_req_i),
        .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
        .sp_rdata_ff(sp_rdata_ff), .sp_rvalid_ff(sp_rvalid_ff),
        .periph_req_ff(periph_req_ff), .periph_ff(periph_ff),
        .mem_req(mem_req), .mem_req_i(mem_req_i), .mem_rdata_ff(mem_rdata_ff),
        .mem_rvalid_ff(mem_rvalid_ff), .mem_phys_ff(mem_phys_ff));
    // =====================================================================
    // 100 MHz clock
    initial begin
        forever #5 mclk = ~mclk;
    end
    // =====================================================================
    // comparison, verdict and bus tasks
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] st, output logic [1:0] r);
        int i;
        @(posedge mclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= st;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (s_awvalid && s_awready_ff) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready_ff) s_wvalid <= 1'b0;
            if (s_bvalid_ff) break;
        end
        r = s_bresp_ff;
        s_bready <= 1'b0;
        if (i == 50) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int i;
        @(posedge mclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (s_arvalid && s_arready_ff) s_arvalid <= 1'b0;
            if (s_rvalid_ff) break;
        end
        d = s_rdata_ff;
        r = s_rresp_ff;
        s_rready <= 1'b0;
        if (i == 50) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : axi_read
    task automatic set_page(input logic [7:0] a, input logic [2:0] p);
        axi_write(a, {29'h0, p}, 4'hF, rs);
        check("page write resp", rs, SPM_RESP_OKAY);
    endtask : set_page
    task automatic set_mode(input logic m);
        @(posedge mclk);
        paging_mode_select <= m;
        repeat (3) @(posedge mclk);
    endtask : set_mode
    // =====================================================================
    // scenarios
    task automatic t_regs;
        axi_read(SPM_REG_PROG_PAGE, rw, rs);
        check("prog page reset", rw, 32'h0);
        axi_read(SPM_REG_DRD_PAGE, rw, rs);
        check("read page reset", rw, 32'h1);
        axi_read(SPM_REG_DWR_PAGE, rw, rs);
        check("write page reset", rw, 32'h1);
        axi_read(8'h10, rw, rs);
        check("unmapped read resp", rs, SPM_RESP_SLVERR);
        axi_write(8'h10, 32'h5, 4'hF, rs);
        check("unmapped write resp", rs, SPM_RESP_SLVERR);
        axi_write(SPM_REG_PROG_PAGE, 32'h3, 4'h0, rs);
        axi_read(SPM_REG_PROG_PAGE, rw, rs);
        check("masked write", rw, 32'h0);
    endtask : t_regs
    task automatic t_scratch;
        core.sp_access(1, 1, 0, 2'h0, 8'h90, 8'hA5, rv, pv, rd, pf);
        core.sp_access(0, 0, 0, 2'h0, 8'h90, 8'h00, rv, pv, rd, pf);
        check("direct upper fwd", {pv, rv, pf.we, pf.addr}, 11'h490);
        core.sp_access(0, 1, 0, 2'h0, 8'h90, 8'h00, rv, pv, rd, pf);
        check("indirect upper", {pv, rv, rd}, 10'h1A5);
        core.sp_access(1, 0, 0, 2'h0, 8'h7F, 8'h3C, rv, pv, rd, pf);
        core.sp_access(0, 1, 0, 2'h0, 8'h7F, 8'h00, rv, pv, rd, pf);
        check("lower both modes", {pv, rv, rd}, 10'h13C);
        core.sp_access(1, 1, 0, 2'h0, 8'hFF, 8'hC3, rv, pv, rd, pf);
        core.sp_access(0, 1, 0, 2'h0, 8'hFF, 8'h00, rv, pv, rd, pf);
        check("top byte", rd, 8'hC3);
        for (int b = 0; b < 4; b++) begin
            core.sp_access(1, 1, 1, b[1:0], 8'hFF, 8'h70 + b[7:0], rv, pv, rd, pf);
            core.sp_access(0, 0, 0, 2'h0, 8'h07 + 8 * b[7:0], 8'h00, rv, pv, rd, pf);
            check("bank register", rd, 8'h70 + b[7:0]);
        end
    endtask : t_scratch
    task automatic t_mode0;
        set_page(SPM_REG_DWR_PAGE, 3'h7);
        core.mem_access(SPM_DATA_WRITE, 16'hABCD, 8'h5A, rv, rd, ph);
        check("mode0 write phys", {rv, ph}, 18'h1ABCD);
        core.mem_access(SPM_DATA_READ, 16'hABCD, 8'h00, rv, rd, ph);
        check("mode0 read", {rv, rd}, 9'h15A);
        set_page(SPM_REG_PROG_PAGE, 3'h1);
        core.mem_access(SPM_FETCH, 16'hABCD, 8'h00, rv, rd, ph);
        check("fetch data byte", {rv, rd, ph}, 26'h2B5ABCD);
        set_page(SPM_REG_DRD_PAGE, 3'h6);
        core.mem_access(SPM_DATA_READ, 16'hABCD, 8'h00, rv, rd, ph);
        check("mode0 page 0", ph, 17'h0ABCD);
    endtask : t_mode0
    task automatic t_mode1;
        set_mode(1'b1);
        axi_read(SPM_REG_STATUS, rw, rs);
        check("status mode", rw[0], 1'b1);
        check("status phys", rw[24:8], 17'h0ABCD);
        for (int p = 0; p < 8; p++) begin
            set_page(SPM_REG_DWR_PAGE, p[2:0]);
            core.mem_access(SPM_DATA_WRITE, 16'hFFFF, 8'h30 + p[7:0], rv, rd, ph);
            check("mode1 phys", ph, {p[2:0], 14'h3FFF});
        end
        set_page(SPM_REG_PROG_PAGE, 3'h5);
        core.mem_access(SPM_CODE_READ, 16'h3FFF, 8'h00, rv, rd, ph);
        check("code read page 5", {rv, rd}, 9'h135);
        set_mode(1'b0);
        set_page(SPM_REG_DRD_PAGE, 3'h1);
        core.mem_access(SPM_DATA_READ, 16'h7FFF, 8'h00, rv, rd, ph);
        check("cross mode view", {rd, ph}, 25'h6B7FFF);
    endtask : t_mode1
    // =====================================================================
    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        t_regs();
        t_scratch();
        t_mode0();
        t_mode1();
        tally_and_finish();
    end
endmodule : spm_mapper_test
